//--- hdl/tlc_top.sv
// timer link input routing, control register and capture over apb
`timescale 1ns/100ps
module tlc_top
  import tlc_pkg::*;
#(
  parameter int CW = 8
)
(
  // apb
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // sync inputs
  input  wire logic          spare_hsync_in,
  input  wire logic          spare_vsync_in,
  input  wire logic          composite_sync_in,
  input  wire logic          hsync_in,
  input  wire logic          vsync_in,
  input  wire logic          sync_separator_vertical,
  input  wire logic          generated_vsync,
  // normal timer pins
  input  wire logic          frt_capture_a,
  input  wire logic          frt_capture_b,
  input  wire logic          frt_capture_c,
  input  wire logic          frt_capture_d,
  input  wire logic          timer_one_ext_in,
  input  wire logic          timer_x_ext_in,
  input  wire logic          timer_y_ext_in,
  input  wire logic          timer_one_out,
  input  wire logic [CW-1:0] timer_counter,
  // routed timer inputs
  output tlc_route_t         route,
  output logic               internal_hsync,
  output logic               internal_vsync,
  // interrupt
  output logic               irq
);
  initial if (CW < 1 || CW > 32) $error("tlc_top: CW out of range");

  // ==========================================================================
  // registers
  logic [7:0]         ctrl_r, ctrl_nxt;
  logic               arm_seen0_r, arm_seen0_nxt;
  logic [TLC_NEV-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [31:0]        prdata_nxt;
  logic [CW-1:0]      gcap, rcap, fcap;
  logic               rise_ev, fall_ev, gcap_ev;
  logic               wr, rd, rd_setup;
  tlc_mode_t          mode;
  tlc_route_t         route_nxt;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign mode    = tlc_mode_t'(ctrl_r[TLC_MODE_HI_POS:TLC_MODE_LO_POS]);
  assign irq     = |(stat_r & mask_r);

  // ==========================================================================
  // sync selection
  always_comb
  begin
    case (mode)
      TLC_MODE_NONE: internal_hsync = spare_hsync_in;
      TLC_MODE_SOG:  internal_hsync = composite_sync_in;
      default:       internal_hsync = hsync_in;
    endcase
    case (mode)
      TLC_MODE_NONE: internal_vsync = spare_vsync_in;
      TLC_MODE_SEP:  internal_vsync = vsync_in;
      default:       internal_vsync = sync_separator_vertical;
    endcase
  end

  // ==========================================================================
  // timer input routing
  always_comb
  begin
    if (ctrl_r[TLC_ROUTE_POS])
    begin
      route_nxt.frt_a   = internal_vsync;
      route_nxt.frt_b   = timer_one_out;
      route_nxt.frt_c   = spare_vsync_in;
      route_nxt.frt_d   = internal_hsync;
      route_nxt.one_clk = internal_hsync;
      route_nxt.one_rst = !internal_vsync;
      route_nxt.x_clk   = internal_hsync;
      route_nxt.x_rst   = internal_hsync;
      route_nxt.y_clk   = generated_vsync;
      route_nxt.y_rst   = generated_vsync;
    end
    else
    begin
      route_nxt.frt_a   = frt_capture_a;
      route_nxt.frt_b   = frt_capture_b;
      route_nxt.frt_c   = frt_capture_c;
      route_nxt.frt_d   = frt_capture_d;
      route_nxt.one_clk = timer_one_ext_in;
      route_nxt.one_rst = timer_one_ext_in;
      route_nxt.x_clk   = timer_x_ext_in;
      route_nxt.x_rst   = timer_x_ext_in;
      route_nxt.y_clk   = timer_y_ext_in;
      route_nxt.y_rst   = timer_y_ext_in;
    end
  end

  // ==========================================================================
  // capture
  tlc_capture #(.CW(CW)) u_cap (
    .pclk    (pclk),
    .presetn (presetn),
    .rst_in  (route.x_rst),
    .armed   (ctrl_r[TLC_ARM_POS]),
    .count   (timer_counter),
    .gcap_r  (gcap),
    .rcap_r  (rcap),
    .fcap_r  (fcap),
    .rise_ev (rise_ev),
    .fall_ev (fall_ev),
    .gcap_ev (gcap_ev)
  );

  // ==========================================================================
  // register writes and reads
  always_comb
  begin
    ctrl_nxt      = ctrl_r;
    arm_seen0_nxt = arm_seen0_r;
    stat_nxt      = stat_r;
    mask_nxt      = mask_r;
    prdata_nxt    = prdata;
    // loaded in the setup cycle so read data stands at the access edge
    if (rd_setup)
    begin
      if (paddr == TLC_CTRL_OFS)
        prdata_nxt = {24'h000000, ctrl_r};
      else if (paddr == TLC_GCAP_OFS)
        prdata_nxt = 32'(gcap);
      else if (paddr == TLC_RCAP_OFS)
        prdata_nxt = 32'(rcap);
      else if (paddr == TLC_FCAP_OFS)
        prdata_nxt = 32'(fcap);
      else if (paddr == TLC_STAT_OFS)
        prdata_nxt = 32'(stat_r);
      else if (paddr == TLC_MASK_OFS)
        prdata_nxt = 32'(mask_r);
      else
        prdata_nxt = 32'h00000000;
    end
    // arm may be set only after software has seen it at 0
    if (rd && paddr == TLC_CTRL_OFS)
      arm_seen0_nxt = !prdata[TLC_ARM_POS];
    if (wr)
    begin
      if (paddr == TLC_CTRL_OFS)
      begin
        ctrl_nxt = (ctrl_r & ~TLC_CTRL_WMASK) | (pwdata[7:0] & TLC_CTRL_WMASK);
        if (pwdata[TLC_ARM_POS] && arm_seen0_r)
          ctrl_nxt[TLC_ARM_POS] = 1'b1;
        arm_seen0_nxt = 1'b0;
      end
      else if (paddr == TLC_STAT_OFS)
        stat_nxt = stat_r & ~pwdata[TLC_NEV-1:0];
      else if (paddr == TLC_MASK_OFS)
        mask_nxt = pwdata[TLC_NEV-1:0];
    end
    if (fall_ev)
      ctrl_nxt[TLC_ARM_POS] = 1'b0;
    // set wins over clear
    stat_nxt[TLC_ST_RISE] = stat_nxt[TLC_ST_RISE] | rise_ev;
    stat_nxt[TLC_ST_FALL] = stat_nxt[TLC_ST_FALL] | fall_ev;
    stat_nxt[TLC_ST_GCAP] = stat_nxt[TLC_ST_GCAP] | gcap_ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r      <= TLC_CTRL_RST;
      arm_seen0_r <= 1'b0;
      stat_r      <= '0;
      mask_r      <= '0;
      prdata      <= 32'h00000000;
      route       <= '0;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      arm_seen0_r <= arm_seen0_nxt;
      stat_r      <= stat_nxt;
      mask_r      <= mask_nxt;
      prdata      <= prdata_nxt;
      route       <= route_nxt;
    end
  end
endmodule : tlc_top

//--- hdl/tlc_pkg.sv
// package of constants and types for the timer link input control block
// Function
// - bits 7:6 select sync mode: none, sync-on-green, composite, separate; reset 0.
// - internal hsync from spare hsync, composite sync, or hsync input by mode.
// - internal vsync from spare vsync, separator vertical, or vsync input by mode.
// - bit 5 route enable, reset 0; when 0 timers keep normal pin inputs.
// - route enable 1 feeds timers from internal sync signals as tabulated.
// - with route enable 1, timer x reset input is driven by internal hsync.
// - bit 4 capture arm, reset 0, arms one pulse-width measurement on timer x.
// - armed: rising edge captures counter to rise reg, next fall to fall reg.
// - after the fall capture the arm bit clears itself.
// - arm bit sets only on write of 1 after reading it as 0.
// - timer x has general, rise and fall capture registers.
package tlc_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] TLC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] TLC_GCAP_OFS   = 12'h004;
  localparam logic [11:0] TLC_RCAP_OFS   = 12'h008;
  localparam logic [11:0] TLC_FCAP_OFS   = 12'h00c;
  localparam logic [11:0] TLC_STAT_OFS   = 12'h010;
  localparam logic [11:0] TLC_MASK_OFS   = 12'h014;

  // ==========================================================================
  // control fields
  localparam int          TLC_MODE_HI_POS = 7;
  localparam int          TLC_MODE_LO_POS = 6;
  localparam int          TLC_ROUTE_POS   = 5;
  localparam int          TLC_ARM_POS     = 4;
  localparam logic [7:0]  TLC_CTRL_RST    = 8'h00;
  localparam logic [7:0]  TLC_CTRL_WMASK  = 8'he0;

  // status bits: 0 rise captured, 1 fall captured, 2 general capture
  localparam int          TLC_ST_RISE     = 0;
  localparam int          TLC_ST_FALL     = 1;
  localparam int          TLC_ST_GCAP     = 2;
  localparam int          TLC_NEV         = 3;

  typedef enum logic [1:0] {
    TLC_MODE_NONE,
    TLC_MODE_SOG,
    TLC_MODE_COMP,
    TLC_MODE_SEP
  } tlc_mode_t;

  typedef struct packed {
    logic frt_a;
    logic frt_b;
    logic frt_c;
    logic frt_d;
    logic one_clk;
    logic one_rst;
    logic x_clk;
    logic x_rst;
    logic y_clk;
    logic y_rst;
  } tlc_route_t;

endpackage : tlc_pkg

//--- hdl/tlc_capture.sv
// one-shot pulse-width capture for timer x
`timescale 1ns/100ps
module tlc_capture
  import tlc_pkg::*;
#(
  parameter int CW = 8
)
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // signals
  input  wire logic          rst_in,
  input  wire logic          armed,
  input  wire logic [CW-1:0] count,
  // results
  output logic [CW-1:0]      gcap_r,
  output logic [CW-1:0]      rcap_r,
  output logic [CW-1:0]      fcap_r,
  output logic               rise_ev,
  output logic               fall_ev,
  output logic               gcap_ev
);
  initial if (CW < 1 || CW > 32) $error("tlc_capture: CW out of range");

  logic          prev_r, prev_nxt;
  logic          got_rise_r, got_rise_nxt;
  logic [CW-1:0] gcap_nxt, rcap_nxt, fcap_nxt;

  always_comb
  begin
    prev_nxt     = rst_in;
    got_rise_nxt = got_rise_r;
    gcap_nxt     = gcap_r;
    rcap_nxt     = rcap_r;
    fcap_nxt     = fcap_r;
    rise_ev      = 1'b0;
    fall_ev      = 1'b0;
    gcap_ev      = 1'b0;
    if (rst_in && !prev_r)
    begin
      gcap_nxt = count;
      gcap_ev  = 1'b1;
    end
    if (!armed)
      got_rise_nxt = 1'b0;
    else if (rst_in && !prev_r && !got_rise_r)
    begin
      rcap_nxt     = count;
      got_rise_nxt = 1'b1;
      rise_ev      = 1'b1;
    end
    else if (!rst_in && prev_r && got_rise_r)
    begin
      fcap_nxt     = count;
      got_rise_nxt = 1'b0;
      fall_ev      = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_r     <= 1'b0;
      got_rise_r <= 1'b0;
      gcap_r     <= '0;
      rcap_r     <= '0;
      fcap_r     <= '0;
    end
    else
    begin
      prev_r     <= prev_nxt;
      got_rise_r <= got_rise_nxt;
      gcap_r     <= gcap_nxt;
      rcap_r     <= rcap_nxt;
      fcap_r     <= fcap_nxt;
    end
  end
endmodule : tlc_capture

//--- dv/tlc_assertions.sv
// checker of routing, readback and interrupt masking
`timescale 1ns/100ps
module tlc_assertions
  import tlc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        spare_hsync_in,
  input wire logic        spare_vsync_in,
  input wire logic        composite_sync_in,
  input wire logic        hsync_in,
  input wire logic        vsync_in,
  input wire logic        sync_separator_vertical,
  input wire logic        timer_x_ext_in,
  input wire logic        timer_one_out,
  input wire tlc_route_t  route,
  input wire logic        internal_hsync,
  input wire logic        internal_vsync,
  input wire logic        irq
);
  logic [1:0] mode_r;
  logic       en_r;
  logic [2:0] mask_r;
  logic       wr;
  logic       rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode_r <= 2'h0;
      en_r   <= 1'b0;
      mask_r <= 3'h0;
    end
    else if (wr && paddr == TLC_CTRL_OFS)
    begin
      mode_r <= pwdata[7:6];
      en_r   <= pwdata[5];
    end
    else if (wr && paddr == TLC_MASK_OFS)
      mask_r <= pwdata[2:0];
  hs_mux_a: assert property (
    internal_hsync == (mode_r == 2'h0 ? spare_hsync_in :
                       mode_r == 2'h1 ? composite_sync_in : hsync_in))
    else $error("internal hsync source wrong");
  vs_mux_a: assert property (
    internal_vsync == (mode_r == 2'h0 ? spare_vsync_in :
                       mode_r == 2'h3 ? vsync_in : sync_separator_vertical))
    else $error("internal vsync source wrong");
  route_off_a: assert property (
    $past(presetn) && !$past(en_r) |-> route.x_rst == $past(timer_x_ext_in))
    else $error("normal pin routing wrong");
  route_on_a: assert property (
    $past(presetn) && $past(en_r) |-> route.frt_b == $past(timer_one_out)
      && route.one_rst == !$past(internal_vsync))
    else $error("sync routing wrong");
  x_reset_a: assert property (
    $past(presetn) && $past(en_r) |-> route.x_rst == $past(internal_hsync))
    else $error("timer x reset source wrong");
  ctrl_read_a: assert property (
    rd && paddr == TLC_CTRL_OFS |-> prdata[7:5] == {mode_r, en_r})
    else $error("control readback wrong");
  irq_mask_a: assert property (
    mask_r == 3'h0 |-> !irq)
    else $error("masked interrupt raised");
  unmapped_read_a: assert property (
    rd && paddr == 12'h020 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : tlc_assertions

bind tlc_top tlc_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .spare_hsync_in(spare_hsync_in), .spare_vsync_in(spare_vsync_in),
  .composite_sync_in(composite_sync_in), .hsync_in(hsync_in), .vsync_in(vsync_in),
  .sync_separator_vertical(sync_separator_vertical), .timer_x_ext_in(timer_x_ext_in),
  .timer_one_out(timer_one_out), .route(route), .internal_hsync(internal_hsync),
  .internal_vsync(internal_vsync), .irq(irq));

//--- dv/tlc_sync_model.sv
// sync sources and timer x counter facing the block
`timescale 1ns/100ps
module tlc_sync_model
#(
  parameter int CW = 8
)
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // control: 0 random, 1 hold, 2 hsync sources follow hs_lvl
  input  wire logic [1:0]    smode,
  input  wire logic          hs_lvl,
  input  wire logic [CW-1:0] cnt_in,
  // outputs
  output logic [6:0]         srcs,
  output logic [CW-1:0]      count
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      srcs  <= 7'h0;
      count <= '0;
    end
    else
    begin
      count <= (smode == 2'h0) ? CW'($urandom) : cnt_in;
      if (smode == 2'h0)
        srcs <= 7'($urandom);
      else if (smode == 2'h2)
        srcs <= {srcs[6:4], hs_lvl, hs_lvl, srcs[1], hs_lvl};
    end
endmodule : tlc_sync_model

//--- dv/tb_top.sv
// self-checking bench for the timer link input control block
`timescale 1ns/100ps
module tb_top
  import tlc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ihs, ivs, irq, hs_lvl, eh, ev;
  logic [11:0] paddr, ex;
  logic [31:0] pwdata, prdata;
  logic [31:0] exp_q[$];
  logic [7:0]  pins, cnt_in, count;
  logic [6:0]  srcs;
  logic [1:0]  smode, m;
  tlc_route_t  route;
  int          failures, n_tests, i;

  tlc_sync_model #(.CW(8)) i_model (.pclk(pclk), .presetn(presetn), .smode(smode),
    .hs_lvl(hs_lvl), .cnt_in(cnt_in), .srcs(srcs), .count(count));
  tlc_top #(.CW(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spare_hsync_in(srcs[0]), .spare_vsync_in(srcs[1]),
    .composite_sync_in(srcs[2]), .hsync_in(srcs[3]), .vsync_in(srcs[4]),
    .sync_separator_vertical(srcs[5]), .generated_vsync(srcs[6]),
    .frt_capture_a(pins[7]), .frt_capture_b(pins[6]), .frt_capture_c(pins[5]),
    .frt_capture_d(pins[4]), .timer_one_ext_in(pins[3]), .timer_x_ext_in(pins[2]),
    .timer_y_ext_in(pins[1]), .timer_one_out(pins[0]), .timer_counter(count),
    .route(route), .internal_hsync(ihs), .internal_vsync(ivs), .irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ==========================================================================
  // tasks
  task automatic complete_run;
    if (exp_q.size() != 0)
      failures++;
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      failures++;
      complete_run();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("Error %0t: routed signal mismatch", $time);
    end
  endtask : chk

  task automatic pulse(input logic l, input logic [7:0] c);
    hs_lvl <= l;
    cnt_in <= c;
    repeat (4) @(posedge pclk);
  endtask : pulse

  // every completed transfer: no error; read data taken at the access edge
  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      n_tests++;
      if (pslverr !== 1'b0)
      begin
        failures++;
        $display("Error %0t: slave error raised", $time);
      end
      if (pwrite === 1'b0)
      begin
        n_tests++;
        if (exp_q.size() == 0)
        begin
          failures++;
          $display("Error %0t: read with no expectation", $time);
        end
        else
        begin
          if (prdata !== exp_q[0])
          begin
            failures++;
            $display("Error %0t: read data mismatch", $time);
          end
          void'(exp_q.pop_front());
        end
      end
    end

  // ==========================================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h3794));
    {presetn, psel, penable, pwrite, hs_lvl} = 5'h00;
    {paddr, pwdata, pins, cnt_in, smode} = 62'h0;
    failures = 0;
    n_tests  = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(TLC_CTRL_OFS, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      smode <= 2'h0;
      pins  <= 8'($urandom);
      apb(TLC_CTRL_OFS, 1'b1, {24'h0, i[1:0], i[2], 5'h0});
      smode <= 2'h1;
      rd(TLC_CTRL_OFS, {24'h0, i[1:0], i[2], 5'h0});
      m  = i[1:0];
      eh = (m == 2'h0) ? srcs[0] : (m == 2'h1) ? srcs[2] : srcs[3];
      ev = (m == 2'h0) ? srcs[1] : (m == 2'h3) ? srcs[4] : srcs[5];
      ex = i[2] ? {eh, ev, ev, pins[0], srcs[1], eh, eh, !ev, eh, eh, srcs[6], srcs[6]}
                : {eh, ev, pins[7:4], pins[3], pins[3], pins[2], pins[2], pins[1], pins[1]};
      chk({ihs, ivs, route}, ex);
    end
    apb(TLC_CTRL_OFS, 1'b1, 32'he0);
    smode  <= 2'h2;
    pulse(1'b1, 8'h11);
    apb(TLC_STAT_OFS, 1'b1, 32'h7);
    apb(TLC_CTRL_OFS, 1'b1, 32'hf0);
    rd(TLC_CTRL_OFS, 32'he0);
    apb(TLC_CTRL_OFS, 1'b1, 32'hf0);
    rd(TLC_CTRL_OFS, 32'hf0);
    pulse(1'b0, 8'h22);
    rd(TLC_FCAP_OFS, 32'h0);
    pulse(1'b1, 8'h33);
    pulse(1'b0, 8'h44);
    rd(TLC_RCAP_OFS, 32'h33);
    rd(TLC_FCAP_OFS, 32'h44);
    rd(TLC_CTRL_OFS, 32'he0);
    rd(TLC_STAT_OFS, 32'h7);
    chk({11'h0, irq}, 12'h0);
    apb(TLC_MASK_OFS, 1'b1, 32'h3);
    chk({11'h0, irq}, 12'h1);
    apb(TLC_STAT_OFS, 1'b1, 32'h7);
    chk({11'h0, irq}, 12'h0);
    pulse(1'b1, 8'h55);
    pulse(1'b0, 8'h66);
    rd(TLC_RCAP_OFS, 32'h33);
    rd(TLC_GCAP_OFS, 32'h55);
    rd(TLC_STAT_OFS, 32'h4);
    apb(12'h020, 1'b1, 32'hffff_ffff);
    rd(12'h020, 32'h0);
    complete_run();
  end
endmodule : tb_top
